// [hw/csrp_pkg.sv]
// Package of constants for the configuration-synchronised reset pulse block
package csrp_pkg;
    // Reset and idle levels
    localparam logic CSRP_PULSE_RESET = 1'b0;
    localparam logic CSRP_IO_EN_RESET = 1'b0;
    localparam logic CSRP_CFG_ACTIVE_RESET = 1'b0;
    // Width of the user-logic output group held off during configuration
    localparam int CSRP_USER_WIDTH = 8;
    // Start-up states
    typedef enum logic [1:0] {
        CSRP_CONFIG = 2'b00,
        CSRP_ARMED = 2'b01,
        CSRP_PULSE = 2'b10,
        CSRP_RUN = 2'b11
    } csrp_state_type;
endpackage

// [hw/csrp_pulse_ff.sv]
// Single pulse flip-flop with its own feedback gate
`timescale 1ns/10ps
`default_nettype none
module csrp_pulse_ff
    import csrp_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_cfg_reset,
    input wire logic i_config_done_low_pin,
    output logic o_q,
    output logic o_d
);
    // =====================================
    // Feedback gate
    // Done low forces D high; Q high forces D low while done is high
    assign o_d = ~i_config_done_low_pin | ~o_q;

    // =====================================
    // Flip-flop, cleared by the configuration reset
    always_ff @(posedge i_clk_sys or posedge i_cfg_reset) begin
        if (i_cfg_reset) begin
            o_q <= CSRP_PULSE_RESET;
        end else begin
            o_q <= o_d & i_config_done_low_pin;
        end
    end
endmodule
`default_nettype wire

// [hw/csrp_top.sv]
// Start-up sequencer with synchronous global reset pulse
// Operation
// - During configuration, user pins float and all user flip-flops stay reset.
// - Daisy-chained devices go active on the same configuration clock edge.
// - Device goes active on rising configuration clock edge, outputs together, sampled and registered on the system clock.
// - Combinational logic works as soon as its configuration arrives.
// - Output enable control may be active before configuration ends.
// - Done-low pin holds D high; configuration reset keeps Q low.
// - Internal and external pull-ups keep the reset line high during configuration.
// - After configuration, done pin goes high; Q low, D high, reset high.
// - First system clock sets Q, D goes low, driver pulls reset low.
// - When Q returns low, driver releases reset, giving one short pulse.
// - Uses one logic block and one pin; done pin unavailable as I/O.
`timescale 1ns/10ps
`default_nettype none
module csrp_top
    import csrp_pkg::*;
#(
    parameter int USER_WIDTH = CSRP_USER_WIDTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_config_shift_clock,
    input wire logic i_config_complete,
    input wire logic i_reset_line,
    input wire logic [USER_WIDTH-1:0] i_user_out,
    input wire logic [USER_WIDTH-1:0] i_user_out_en,
    output logic o_config_done_low_pin,
    output logic o_active,
    output logic o_reset_line_out,
    output logic o_reset_line_oe,
    output logic o_reset_pull_up,
    output logic [USER_WIDTH-1:0] o_user_out,
    output logic [USER_WIDTH-1:0] o_user_oe,
    output logic o_global_reset_n,
    output logic o_pulse_seen
);
    // =====================================
    // Go-active point
    // Configuration clock is sampled as an ordinary synchronous input; its rising edge while
    // configuration is complete starts the device. Every chained device sees the same edge.
    logic config_shift_clock_prev;
    logic active;
    logic pulse_seen;
    logic [USER_WIDTH-1:0] user_out;
    wire config_shift_clock_rise = i_config_shift_clock & ~config_shift_clock_prev;
    wire go_active = i_config_complete & config_shift_clock_rise & ~active;
    wire cfg_reset = ~active;

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            config_shift_clock_prev <= 1'b0;
            active <= CSRP_CFG_ACTIVE_RESET;
        end else begin
            config_shift_clock_prev <= i_config_shift_clock;
            if (go_active) begin
                active <= 1'b1;
            end
        end
    end

    // =====================================
    // Done pin dedicated to the pulse circuit, never user I/O
    assign o_config_done_low_pin = active;
    assign o_active = active;

    // =====================================
    // Pulse flip-flop
    // Done input drops once the pulse is seen, else Q would toggle every cycle
    logic q;
    logic d;
    csrp_pulse_ff u_pulse_ff (
        .i_clk_sys(i_clk_sys),
        .i_cfg_reset(i_rst | cfg_reset),
        .i_config_done_low_pin(active & ~pulse_seen),
        .o_q(q),
        .o_d(d)
    );

    // =====================================
    // Open-drain reset driver: only ever drives low; pull-up always present
    assign o_reset_line_out = 1'b0;
    assign o_reset_line_oe = q;
    assign o_reset_pull_up = 1'b1;
    // Global reset is held low until go-active, then follows the pad, so the pulse resets the whole chip
    assign o_global_reset_n = active & i_reset_line;

    // =====================================
    // User outputs: data is registered and held at zero until the cycle after go-active, enables are pre-armed,
    // so drivers turn on glitch-free with every other output at go-active.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            user_out <= '0;
        end else if (cfg_reset) begin
            user_out <= '0;
        end else begin
            user_out <= i_user_out;
        end
    end
    assign o_user_out = user_out;
    assign o_user_oe = active ? i_user_out_en : {USER_WIDTH{CSRP_IO_EN_RESET}};

    // =====================================
    // One pulse only: records that the reset pulse has completed
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pulse_seen <= 1'b0;
        end else if (cfg_reset) begin
            pulse_seen <= 1'b0;
        end else if (q) begin
            pulse_seen <= 1'b1;
        end
    end
    assign o_pulse_seen = pulse_seen;

    // =====================================
    // Checks
    chk_cfg_outputs_off: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !active |-> (o_user_oe == '0 && !q))
        else $error("User outputs or pulse active during configuration");
    chk_go_on_edge: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(active) |-> $past(i_config_complete) && $past(i_config_shift_clock) && !$past(config_shift_clock_prev))
        else $error("Went active without configuration clock rising edge");
    chk_d_high_cfg: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !active |-> d && !q)
        else $error("Pulse flip-flop not held during configuration");
    chk_pull_up_held: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !active |-> !o_reset_line_oe && o_reset_pull_up)
        else $error("Reset line driven during configuration");
    chk_armed_state: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(active) |-> !q && d && !o_reset_line_oe)
        else $error("Pulse circuit not armed at go-active");
    chk_pulse_starts: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(active) |=> q && o_reset_line_oe)
        else $error("Reset pulse did not start on first system clock");
    chk_pulse_one_cycle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        active && q |=> !q [*3])
        else $error("Reset pulse longer than one cycle or repeated");
    chk_enable_prearm: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(active) |-> o_user_oe == i_user_out_en)
        else $error("Output enables not applied at go-active");
    chk_user_reg_held: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !active |-> user_out == '0)
        else $error("User output register not held during configuration");
    chk_pulse_seen_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pulse_seen |=> pulse_seen)
        else $error("Pulse record lost while running");
    chk_no_repeat: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        pulse_seen |-> !q && !o_reset_line_oe)
        else $error("Reset pulse repeated after completion");
    chk_active_stays: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        active |=> active)
        else $error("Device left active state without reset");
    chk_refuse_incomplete: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_config_complete && !active |=> !active)
        else $error("Went active before configuration complete");
endmodule
`default_nettype wire

// [verification/csrp_far_model.sv]
// Far-side model: configuration clock source and pulled-up global reset pad
`timescale 1ns/10ps
`default_nettype none
module csrp_far_model (
    input wire logic i_clk_sys,
    input wire logic i_run,
    input wire logic i_reset_line_out,
    input wire logic i_reset_line_oe,
    output logic o_config_shift_clock,
    output logic o_reset_line
);
    // Configuration clock stands still while the loader is idle
    always @(negedge i_clk_sys) begin
        if (i_run) begin
            o_config_shift_clock <= ~o_config_shift_clock;
        end else begin
            o_config_shift_clock <= 1'b0;
        end
    end
    // External pull-up holds the pad high unless the open-drain driver pulls it
    assign o_reset_line = i_reset_line_oe ? i_reset_line_out : 1'b1;
endmodule
`default_nettype wire

// [verification/config_sync_reset_pulse_test.sv]
// Testbench for the start-up sequencer and its reset pulse
`timescale 1ns/10ps
`default_nettype none
module config_sync_reset_pulse_test;
    import csrp_pkg::*;
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, complete = 1'b0, config_shift_clock, pad;
    logic [7:0] uo = 8'h00, ue = 8'h00, u_out, u_oe;
    logic done_pin, active, rl_out, rl_oe, pull_up, grn, seen;
    int n_mismatch = 0, checked = 0;
    csrp_top dut_u (.i_clk_sys(clk), .i_rst(rst), .i_config_shift_clock(config_shift_clock), .i_config_complete(complete),
        .i_reset_line(pad), .i_user_out(uo), .i_user_out_en(ue), .o_config_done_low_pin(done_pin),
        .o_active(active), .o_reset_line_out(rl_out), .o_reset_line_oe(rl_oe), .o_reset_pull_up(pull_up),
        .o_user_out(u_out), .o_user_oe(u_oe), .o_global_reset_n(grn), .o_pulse_seen(seen));
    csrp_far_model far_u (.i_clk_sys(clk), .i_run(run), .i_reset_line_out(rl_out), .i_reset_line_oe(rl_oe),
        .o_config_shift_clock(config_shift_clock), .o_reset_line(pad));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic check(input string name, input logic [7:0] seen_v, input logic [7:0] exp_v);
        checked++;
        if (seen_v !== exp_v) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp_v, seen_v);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic step();
        @(negedge clk);
        #1;
    endtask
    task automatic do_reset();
        @(negedge clk);
        rst = 1'b1;
        run = 1'b0;
        complete = 1'b0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
    endtask
    // Status packed as done, active, oe, global reset, seen, pull-up, pad data, pad
    task automatic test_config();
        run = 1'b1;
        repeat (6) begin
            step();
            check("cfg status", {done_pin, active, rl_oe, grn, seen, pull_up, rl_out, pad}, 8'h05);
            check("cfg user oe", u_oe, 8'h00);
            check("cfg user out", u_out, 8'h00);
        end
        $display("test_config done");
    endtask
    task automatic test_start(input logic [7:0] val, input logic [7:0] en);
        uo = val;
        ue = en;
        for (int i = 0; i < 3 && config_shift_clock !== 1'b0; i++) step();
        complete = 1'b1;
        repeat (2) step();
        check("c1 status", {done_pin, active, rl_oe, grn, seen, pull_up, rl_out, pad}, 8'hd5);
        check("c1 user oe", u_oe, en);
        step();
        check("c2 status", {done_pin, active, rl_oe, grn, seen, pull_up, rl_out, pad}, 8'he4);
        step();
        check("c3 status", {done_pin, active, rl_oe, grn, seen, pull_up, rl_out, pad}, 8'hdd);
        // Further configuration clock edges must not start a second pulse
        repeat (4) begin
            step();
            check("run status", {done_pin, active, rl_oe, grn, seen, pull_up, rl_out, pad}, 8'hdd);
        end
        check("user out", u_out, val);
        $display("test_start done");
    endtask
    initial begin
        do_reset();
        test_config();
        test_start(8'h5a, 8'hc3);
        do_reset();
        test_config();
        test_start(8'ha5, 8'h3c);
        test_done();
    end
    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
